// file: hdl/sdl_consts.svh
/*
 * Constants for the segment driver shift/latch block: widths, channel
 * counts, level codes and pin timing figures.
 * Assumes it is included by bare name after the package.
 */
`ifndef SDL_CONSTS_SVH
`define SDL_CONSTS_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define SDL_SECT_BITS      40
`define SDL_CHANNELS       80
`define SDL_LEVEL_W        2

// ----------------------------------------
// Level codes
// ----------------------------------------
`define SDL_LVL_SEL_ONE    2'h0
`define SDL_LVL_SEL_TWO    2'h1
`define SDL_LVL_OFF_ONE    2'h2
`define SDL_LVL_OFF_TWO    2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define SDL_CLK_PERIOD_NS  10
`define SDL_DATA_DELAY_NS  500
`define SDL_DATA_DELAY_CYC (`SDL_DATA_DELAY_NS / `SDL_CLK_PERIOD_NS)

`endif

// file: hdl/sdl_pkg.sv
/*
 * Types for the segment driver shift/latch block.
 * Assumes sdl_consts.svh supplies the numeric constants.
 */
package sdl_pkg;
	typedef logic [39:0] sdl_sect_t;
	typedef logic [1:0]  sdl_level_t;
endpackage

// file: hdl/sdl_edge_if.sv
/*
 * Edge events from the pin sampler to the shift sections.
 * Assumes one clock domain, clk_sys.
 */
interface sdl_edge_if;
	logic shift_fall;
	logic shift_rise;
	logic latch_fall;
	logic phase;
	modport src  (output shift_fall, output shift_rise, output latch_fall, output phase);
	modport sink (input shift_fall, input shift_rise, input latch_fall, input phase);
endinterface

// file: hdl/sdl_section.sv
/*
 * One 40-bit bidirectional shift section with its latch and
 * cascade output.
 * Assumes edge pulses from sdl_edge_if and synchronised pin inputs.
 */
`include "sdl_consts.svh"

module sdl_section (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         reset,
	// Edge events
	sdl_edge_if.sink          ev,
	// Pins, already synchronised
	input  wire logic         dir_sel,
	input  wire logic         left_in,
	input  wire logic         right_in,
	output logic              left_out,
	output logic              left_oe,
	output logic              right_out,
	output logic              right_oe,
	// Latched data
	output sdl_pkg::sdl_sect_t latched
);
	sdl_pkg::sdl_sect_t shreg;
	sdl_pkg::sdl_sect_t next_shreg;
	sdl_pkg::sdl_sect_t next_latched;
	logic               cas;
	logic               next_cas;

	// ----------------------------------------
	// Shift, cascade and latch
	// ----------------------------------------
	always_comb begin
		next_shreg   = shreg;
		next_cas     = cas;
		next_latched = latched;
		if (ev.shift_fall) begin
			if (!dir_sel) begin
				next_shreg = {shreg[38:0], left_in};    // see RULE_02 see RULE_03
			end else begin
				next_shreg = {right_in, shreg[39:1]};   // see RULE_04
			end
		end
		if (ev.shift_rise) begin
			next_cas = dir_sel ? shreg[0] : shreg[39];  // see RULE_05 see RULE_06
		end
		if (ev.latch_fall) begin
			next_latched = shreg;                       // see RULE_08
		end
	end

	// Device has no reset pin; reset only gives a known start
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			shreg   <= 40'h0;
			cas     <= 1'b0;
			latched <= 40'h0;
		end else begin
			shreg   <= next_shreg;
			cas     <= next_cas;
			latched <= next_latched;
		end
	end

	// Pin direction follows the select
	assign left_oe   = dir_sel;   // see RULE_07
	assign right_oe  = ~dir_sel;  // see RULE_07
	assign left_out  = cas;
	assign right_out = cas;

	AST_LATCH_COPY: assert property (@(posedge clk_sys) disable iff (reset)
		ev.latch_fall |=> latched == $past(shreg)) // see RULE_08
		else $error("latch did not copy shift register");
	AST_LATCH_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
		!ev.latch_fall |=> $stable(latched)) // see RULE_08
		else $error("latch changed without strobe");
	AST_SHIFT_RIGHT: assert property (@(posedge clk_sys) disable iff (reset)
		ev.shift_fall && !dir_sel |=> shreg == {$past(shreg[38:0]), $past(left_in)}) // see RULE_03
		else $error("low-direction shift wrong");
	AST_SHIFT_LEFT: assert property (@(posedge clk_sys) disable iff (reset)
		ev.shift_fall && dir_sel |=> shreg == {$past(right_in), $past(shreg[39:1])}) // see RULE_04
		else $error("high-direction shift wrong");
	AST_NO_SHIFT: assert property (@(posedge clk_sys) disable iff (reset)
		!ev.shift_fall |=> $stable(shreg)) // see RULE_02
		else $error("shift register moved without clock edge");
	AST_CAS_LOW: assert property (@(posedge clk_sys) disable iff (reset)
		ev.shift_rise && !dir_sel |=> right_out == $past(shreg[39])) // see RULE_05
		else $error("right cascade bit wrong");
	AST_CAS_HIGH: assert property (@(posedge clk_sys) disable iff (reset)
		ev.shift_rise && dir_sel |=> left_out == $past(shreg[0])) // see RULE_06
		else $error("left cascade bit wrong");
	AST_PIN_DIR: assert property (@(posedge clk_sys) disable iff (reset)
		left_oe != right_oe && left_oe == dir_sel) // see RULE_07
		else $error("pin direction wrong");

	COV_SHIFT_LOW:  cover property (@(posedge clk_sys) ev.shift_fall && !dir_sel);
	COV_SHIFT_HIGH: cover property (@(posedge clk_sys) ev.shift_fall && dir_sel);
	COV_LATCH:      cover property (@(posedge clk_sys) ev.latch_fall && shreg != 40'h0);
endmodule

// file: hdl/sdl_level_map.sv
/*
 * Maps latched bits and the phase input to 2-bit bias level codes.
 * Assumes latched data and phase are on clk_sys.
 */
`include "sdl_consts.svh"

module sdl_level_map (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// Source
	input  wire logic        phase,
	input  wire logic [79:0] bits,
	// Level codes
	output logic [159:0]     segment_out
);
	logic [159:0] next_seg;

	// ----------------------------------------
	// Per-channel selection
	// ----------------------------------------
	// On picks a select level, off a non-select level; phase alternates pair
	genvar g;
	generate
		for (g = 0; g < `SDL_CHANNELS; g++) begin : g_ch
			always_comb begin
				if (bits[g]) begin
					next_seg[2*g +: 2] = phase ? `SDL_LVL_SEL_TWO : `SDL_LVL_SEL_ONE; // see RULE_09 see RULE_10 see RULE_12
				end else begin
					next_seg[2*g +: 2] = phase ? `SDL_LVL_OFF_TWO : `SDL_LVL_OFF_ONE; // see RULE_10 see RULE_12
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			segment_out <= 160'h0;
		end else begin
			segment_out <= next_seg;
		end
	end

	AST_LEVEL_ON: assert property (@(posedge clk_sys) disable iff (reset)
		bits[0] |=> segment_out[1:0] == {1'b0, $past(phase)}) // see RULE_12
		else $error("channel 1 on level wrong");
	AST_LEVEL_OFF: assert property (@(posedge clk_sys) disable iff (reset)
		!reset && !bits[79] |=> segment_out[159:158] == {1'b1, $past(phase)}) // see RULE_12
		else $error("channel 80 off level wrong");
	COV_PHASE_TOGGLE: cover property (@(posedge clk_sys) $changed(phase)); // see RULE_11
endmodule

// file: hdl/sdl_driver.sv
/*
 * Top of the segment driver shift/latch block: pin synchronisers,
 * edge detection, two shift sections and the level mapper.
 * Assumes all pin inputs are asynchronous to clk_sys and that
 * the shift clock stays well below clk_sys/4.
 */
// Overview of operation
// RULE_01 - Two independent sections each have a 40-bit bidirectional register, own select and own pins.
// RULE_02 - Each register moves one place on every falling shift clock edge, taking the serial bit in.
// RULE_03 - With select low data enters at the left pin and moves from bit 1 toward bit 40.
// RULE_04 - With select high data enters at the right pin and moves from bit 40 toward bit 1.
// RULE_05 - With select low the last bit is caught on the rising shift edge and sent out of the right pin.
// RULE_06 - With select high the last bit is caught on the rising shift edge and sent out of the left pin.
// RULE_07 - Select high makes the left pin an output and right an input, select low the reverse.
// RULE_08 - Each falling latch strobe copies every register bit to its latch, held until the next strobe.
// RULE_09 - Every channel picks one of four bias levels from the phase input and its latched bit.
// RULE_10 - Levels one and two are the on levels, levels three and four the off levels.
// RULE_11 - The controller toggles the phase input so each channel alternates and carries no DC.
// RULE_12 - A latched one picks an on level, a zero an off level, phase picks within the pair, coded in 2 bits.
// RULE_13 - Section A drives channels 1 to 40 and section B channels 41 to 80, first bit lowest channel.
`include "sdl_consts.svh"

module sdl_driver (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         reset,
	// Controller clocks and phase
	input  wire logic         shift_clock,
	input  wire logic         latch_strobe,
	input  wire logic         phase_in,
	// Section A pins
	input  wire logic         dir_select_a,
	input  wire logic         left_io_a_in,
	output logic              left_io_a_out,
	output logic              left_io_a_oe,
	input  wire logic         right_io_a_in,
	output logic              right_io_a_out,
	output logic              right_io_a_oe,
	// Section B pins
	input  wire logic         dir_select_b,
	input  wire logic         left_io_b_in,
	output logic              left_io_b_out,
	output logic              left_io_b_oe,
	input  wire logic         right_io_b_in,
	output logic              right_io_b_out,
	output logic              right_io_b_oe,
	// Channel level codes, 2 bits per channel, channel 1 lowest
	output logic [159:0]      segment_out
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	localparam int NSYNC = 9;
	logic [NSYNC-1:0] s1;
	logic [NSYNC-1:0] s2;
	logic [NSYNC-1:0] raw;
	logic             shift_d;
	logic             latch_d;
	logic             next_shift_d;
	logic             next_latch_d;

	assign raw = {phase_in, right_io_b_in, left_io_b_in, dir_select_b,
	              right_io_a_in, left_io_a_in, dir_select_a, latch_strobe, shift_clock};

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			s1 <= '0;
			s2 <= '0;
		end else begin
			s1 <= raw;
			s2 <= s1;
		end
	end

	// ----------------------------------------
	// Edge detection
	// ----------------------------------------
	// Edges seen two cycles late; shift clock limits keep margin ample
	always_comb begin
		next_shift_d = s2[0];
		next_latch_d = s2[1];
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			shift_d <= 1'b0;
			latch_d <= 1'b0;
		end else begin
			shift_d <= next_shift_d;
			latch_d <= next_latch_d;
		end
	end

	sdl_edge_if ev ();
	assign ev.shift_fall = shift_d & ~s2[0];
	assign ev.shift_rise = ~shift_d & s2[0];
	assign ev.latch_fall = latch_d & ~s2[1];
	assign ev.phase      = s2[8];

	// ----------------------------------------
	// Sections
	// ----------------------------------------
	sdl_pkg::sdl_sect_t lat_a;
	sdl_pkg::sdl_sect_t lat_b;

	// Two independent sections share only the clocks and reset
	sdl_section u_sect_a ( // see RULE_01
		.clk_sys   (clk_sys),
		.reset     (reset),
		.ev        (ev.sink),
		.dir_sel   (s2[2]),
		.left_in   (s2[3]),
		.right_in  (s2[4]),
		.left_out  (left_io_a_out),
		.left_oe   (left_io_a_oe),
		.right_out (right_io_a_out),
		.right_oe  (right_io_a_oe),
		.latched   (lat_a)
	);

	sdl_section u_sect_b ( // see RULE_01
		.clk_sys   (clk_sys),
		.reset     (reset),
		.ev        (ev.sink),
		.dir_sel   (s2[5]),
		.left_in   (s2[6]),
		.right_in  (s2[7]),
		.left_out  (left_io_b_out),
		.left_oe   (left_io_b_oe),
		.right_out (right_io_b_out),
		.right_oe  (right_io_b_oe),
		.latched   (lat_b)
	);

	// ----------------------------------------
	// Output stage
	// ----------------------------------------
	sdl_level_map u_map (
		.clk_sys     (clk_sys),
		.reset       (reset),
		.phase       (ev.phase),
		.bits        ({lat_b, lat_a}), // see RULE_13
		.segment_out (segment_out)
	);

	// Sampled reset in the antecedent: output stage still holds its reset code
	AST_MAP_A: assert property (@(posedge clk_sys) disable iff (reset)
		!reset |=> segment_out[1] == ~$past(lat_a[0])) // see RULE_13
		else $error("channel 1 not from section A bit 1");
	AST_MAP_B: assert property (@(posedge clk_sys) disable iff (reset)
		!reset |=> segment_out[81] == ~$past(lat_b[0])) // see RULE_13
		else $error("channel 41 not from section B bit 1");
	AST_MAP_A_LAST: assert property (@(posedge clk_sys) disable iff (reset)
		!reset |=> segment_out[79] == ~$past(lat_a[39])) // see RULE_13
		else $error("channel 40 not from section A bit 40");
	AST_MAP_B_LAST: assert property (@(posedge clk_sys) disable iff (reset)
		!reset |=> segment_out[159] == ~$past(lat_b[39])) // see RULE_13
		else $error("channel 80 not from section B bit 40");
	AST_PHASE_OUT: assert property (@(posedge clk_sys) disable iff (reset)
		!reset |=> segment_out[0] == $past(s2[8])) // see RULE_09
		else $error("channel 1 level ignores phase");
	AST_EDGE_EXCL: assert property (@(posedge clk_sys) disable iff (reset)
		!(ev.shift_fall && ev.shift_rise)) // see RULE_02
		else $error("shift rise and fall in one cycle");
	AST_FALL_ONE: assert property (@(posedge clk_sys) disable iff (reset)
		ev.shift_fall |=> !ev.shift_fall) // see RULE_02
		else $error("one shift edge gave two pulses");
	COV_BOTH_DIRS: cover property (@(posedge clk_sys) s2[2] != s2[5]);
endmodule

// file: tb/sdl_ctrl_model.sv
/*
 * Display controller model: shift clock, latch strobe, phase, serial data.
 * Assumes clk_sys at 100 MHz; shift clock period 160 ns, still between frames.
 */
module sdl_ctrl_model (
	// Clock
	input  wire logic clk_sys,
	// Controller outputs
	output logic      shift_clock,
	output logic      latch_strobe,
	output logic      phase_in,
	output logic      data_a,
	output logic      data_b
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		shift_clock = 1'b0;
		latch_strobe = 1'b0;
		phase_in = 1'b0;
		data_a = 1'b0;
		data_b = 1'b1;
	end
	// ------------------------------------
	// Frame, latch, phase
	// ------------------------------------
	// Word bit 39 goes first on a low select, bit 0 first on a high one
	task automatic frame(input logic [39:0] wa, input logic [39:0] wb,
		input logic dra, input logic drb);
		for (int j = 0; j < 40; j++) begin
			@(posedge clk_sys);
			data_a <= dra ? wa[j] : wa[39 - j];
			data_b <= drb ? wb[j] : wb[39 - j];
			shift_clock <= 1'b1;
			repeat (8) @(posedge clk_sys);
			shift_clock <= 1'b0;
			repeat (7) @(posedge clk_sys);
		end
		// Released lines flip so a stale value cannot pass
		@(posedge clk_sys);
		data_a <= ~data_a;
		data_b <= ~data_b;
	endtask
	// Strobe kept clear of the shift clock and 800 ns wide
	task automatic latch();
		repeat (50) @(posedge clk_sys);
		latch_strobe <= 1'b1;
		repeat (80) @(posedge clk_sys);
		latch_strobe <= 1'b0;
		repeat (50) @(posedge clk_sys);
	endtask
	task automatic set_phase(input logic p);
		@(posedge clk_sys);
		phase_in <= p;
	endtask
endmodule

// file: tb/test_segment_driver_shift_latch.sv
/*
 * Self-checking bench: frames in all select pairs, latch, phase, cascade.
 * Assumes latches and shift registers clear to zero on reset.
 */
module test_segment_driver_shift_latch;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, reset, dir_a, dir_b;
	logic sclk, lstb, ph, da, db;
	logic la_out, la_oe, ra_out, ra_oe, lb_out, lb_oe, rb_out, rb_oe;
	logic [159:0] segment_out, prev;
	logic [39:0]  wa, wb, pa, pb;
	logic [159:0] exp_q[$];
	int           mismatches, cmp_count;
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	sdl_ctrl_model model (.clk_sys(clk_sys), .shift_clock(sclk), .latch_strobe(lstb),
		.phase_in(ph), .data_a(da), .data_b(db));
	// Undriven pin halves see the controller's line
	sdl_driver dut (.clk_sys(clk_sys), .reset(reset), .shift_clock(sclk),
		.latch_strobe(lstb), .phase_in(ph), .dir_select_a(dir_a),
		.left_io_a_in(la_oe ? la_out : da), .left_io_a_out(la_out), .left_io_a_oe(la_oe),
		.right_io_a_in(ra_oe ? ra_out : da), .right_io_a_out(ra_out), .right_io_a_oe(ra_oe),
		.dir_select_b(dir_b),
		.left_io_b_in(lb_oe ? lb_out : db), .left_io_b_out(lb_out), .left_io_b_oe(lb_oe),
		.right_io_b_in(rb_oe ? rb_out : db), .right_io_b_out(rb_out), .right_io_b_oe(rb_oe),
		.segment_out(segment_out));
	// ------------------------------------
	// Checking
	// ------------------------------------
	task automatic check(input logic [159:0] got, input logic [159:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [159:0] levels(input logic [79:0] b, input logic p);
		for (int i = 0; i < 80; i++) levels[2 * i +: 2] = {~b[i], p};
	endfunction
	task automatic tally_and_finish();
		if (exp_q.size() != 0) mismatches++;
		$display("TB: %0d compares, %0d mismatches", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Any change of the outputs must match the oldest note
	always @(negedge clk_sys) begin
		if (reset) prev = '0;
		else if (segment_out !== prev) begin
			prev = segment_out;
			if (exp_q.size() == 0) check(segment_out, ~segment_out);
			else check(segment_out, exp_q.pop_front());
		end
	end
	// Old contents leave at the far end, one bit per rising shift edge
	task automatic cascade(input logic sa, input logic sb);
		for (int k = 0; k < 40; k++) begin
			@(posedge sclk);
			repeat (6) @(posedge clk_sys);
			#1;
			check({159'h0, sa ? la_out : ra_out}, {159'h0, sa ? pa[k] : pa[39 - k]});
			check({159'h0, sb ? lb_out : rb_out}, {159'h0, sb ? pb[k] : pb[39 - k]});
		end
	endtask
	// ------------------------------------
	// Tests
	// ------------------------------------
	initial begin
		repeat (10000) @(posedge clk_sys);
		mismatches++;
		tally_and_finish();
	end
	initial begin
		reset = 1'b1;
		dir_a = 1'b0;
		dir_b = 1'b0;
		pa = '0;
		pb = '0;
		mismatches = 0;
		cmp_count = 0;
		void'($urandom(23));
		repeat (5) @(posedge clk_sys);
		exp_q.push_back(levels(80'h0, 1'b0));
		reset <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			wa = 40'({$urandom, $urandom});
			wb = 40'({$urandom, $urandom});
			@(posedge clk_sys);
			dir_a <= i[0];
			dir_b <= i[1];
			repeat (6) @(posedge clk_sys);
			#1;
			check({159'h0, la_oe}, {159'h0, i[0]});
			check({159'h0, ra_oe}, {159'h0, ~i[0]});
			check({159'h0, lb_oe}, {159'h0, i[1]});
			check({159'h0, rb_oe}, {159'h0, ~i[1]});
			fork
				model.frame(wa, wb, i[0], i[1]);
				cascade(i[0], i[1]);
			join
			exp_q.push_back(levels({wb, wa}, 1'b0));
			model.latch();
			pa = wa;
			pb = wb;
			exp_q.push_back(levels({wb, wa}, 1'b1));
			model.set_phase(1'b1);
			repeat (10) @(posedge clk_sys);
			exp_q.push_back(levels({wb, wa}, 1'b0));
			model.set_phase(1'b0);
			repeat (10) @(posedge clk_sys);
			$display("TB: test %0d done", i);
		end
		tally_and_finish();
	end
endmodule
